// ### include/agu_params.svh
// Constants of the address generation unit
`ifndef AGU_PARAMS_SVH
`define AGU_PARAMS_SVH
`define REG_COUNT      32
`define REGFILE_END    16'h001f
`define IO_BASE        16'h0020
`define IO_END         16'h005f
`define SRAM_BASE      16'h0060
`define SRAM_END       16'h00df
`define SRAM_WORDS     128
`define NV_BYTES       256
`define PC_WIDTH       11
`define PC_RESET       11'h000
`define PTR1_LO        5'h1a
`define PTR2_LO        5'h1c
`define PTR3_LO        5'h1e
`define REG_RESET      8'h00
`define PTR_STEP       16'h0001
`define PC_STEP        11'h001
`endif

// ### include/agu_pkg.sv
// Types of the address generation unit
package agu_pkg;
   typedef enum logic [8:0] {
      MODE_NONE      = 9'h001,
      MODE_REG2      = 9'h002,
      MODE_IO        = 9'h004,
      MODE_DIRECT    = 9'h008,
      MODE_DISP      = 9'h010,
      MODE_INDIRECT  = 9'h020,
      MODE_PREDEC    = 9'h040,
      MODE_POSTINC   = 9'h080,
      MODE_CONST     = 9'h100
   } data_mode_t;
   typedef enum logic [3:0] {
      PCM_NEXT     = 4'h1,
      PCM_SKIP2    = 4'h2,
      PCM_INDIRECT = 4'h4,
      PCM_RELATIVE = 4'h8
   } pc_mode_t;
   typedef enum logic [1:0] {
      PTR_FIRST  = 2'h0,
      PTR_SECOND = 2'h1,
      PTR_THIRD  = 2'h2
   } ptr_sel_t;
   typedef enum logic [3:0] {
      REGION_REGFILE = 4'h1,
      REGION_IO      = 4'h2,
      REGION_SRAM    = 4'h4,
      REGION_NONE    = 4'h8
   } region_t;
endpackage : agu_pkg

// ### core/data_decoder.sv
// Data-space region decoder
`timescale 1ns/10ps
`default_nettype none
`include "agu_params.svh"
module data_decoder
   import agu_pkg::*;
(
   input  wire logic [15:0] addr,
   output var  logic [3:0]  region,
   output var  logic [7:0]  offset
);
   always_comb begin
      offset = addr[7:0];
      if (addr <= `REGFILE_END) begin
         region = REGION_REGFILE;
      end else if (addr <= `IO_END) begin
         region = REGION_IO;
         offset = 8'(addr - `IO_BASE);
      end else if (addr <= `SRAM_END) begin
         region = REGION_SRAM;
         offset = 8'(addr - `SRAM_BASE);
      end else begin
         region = REGION_NONE;
      end
   end
endmodule : data_decoder
`default_nettype wire

// ### core/pc_unit.sv
// Program counter next-address logic
`timescale 1ns/10ps
`default_nettype none
`include "agu_params.svh"
module pc_unit
   import agu_pkg::*;
(
   input  wire logic [10:0] pc,
   input  wire logic [3:0]  pc_mode,
   input  wire logic [11:0] rel_k,
   input  wire logic [15:0] ptr3,
   output var  logic [10:0] pc_next
);
   always_comb begin
      case (pc_mode)
         PCM_SKIP2:    pc_next = 11'(pc + 11'h002);
         PCM_INDIRECT: pc_next = ptr3[10:0];
         PCM_RELATIVE: pc_next = 11'(pc + rel_k[10:0] + `PC_STEP);
         default:      pc_next = 11'(pc + `PC_STEP);
      endcase
   end
endmodule : pc_unit
`default_nettype wire

// ### core/address_generation_unit.sv
// Address generation unit with register file, SRAM and nonvolatile space
// Behaviour
// - Registers 26 to 31 form three 16-bit pointer pairs for indirect access
// - Two-register operation completes in one clock cycle
// - Program memory is 2K words, 11-bit program counter
// - First 96 locations registers and I/O, next 128 SRAM, 224 total
// - Direct mode takes 16-bit address from second instruction word
// - I/O direct uses six-bit I/O address and register index
// - I/O data-space address equals I/O address plus 20 hex
// - Displacement mode adds six-bit field to second or third pointer
// - Plain indirect uses unmodified pointer as address
// - Pre-decrement decrements pointer, uses and writes back new value
// - Post-increment uses old pointer, then increments it
// - Constant load: third pointer bits 11 to 1 word, bit 0 byte
// - Indirect jump or call loads counter from third pointer
// - Relative jump or call goes to counter plus k plus one
// - Two-register ops read both, write result to destination
// - Instructions are one or two words long
// - Separate 256-byte nonvolatile space with byte read and write
`timescale 1ns/10ps
`default_nettype none
`include "agu_params.svh"
module address_generation_unit
   import agu_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        instr_valid,
   input  wire logic [8:0]  data_mode,
   input  wire logic        data_write,
   input  wire logic [1:0]  ptr_sel,
   input  wire logic [4:0]  dest_reg,
   input  wire logic [4:0]  source_operand_reg,
   input  wire logic [5:0]  io_addr,
   input  wire logic [5:0]  disp,
   input  wire logic [15:0] second_word,
   input  wire logic [2:0]  alu_op,
   input  wire logic [3:0]  pc_mode,
   input  wire logic [11:0] rel_k,
   input  wire logic [7:0]  io_rdata,
   input  wire logic        nv_write,
   input  wire logic        nv_read,
   input  wire logic [7:0]  nv_addr,
   input  wire logic [7:0]  nv_wdata,
   input  wire logic [15:0] prog_word,
   output logic      [10:0] program_counter,
   output logic      [10:0] prog_addr,
   output logic             const_high_byte,
   output logic      [7:0]  const_byte,
   output logic      [15:0] data_addr,
   output logic      [3:0]  data_region,
   output logic      [5:0]  io_port_addr,
   output logic             io_we,
   output logic             io_re,
   output logic      [7:0]  io_wdata,
   output logic      [7:0]  read_data,
   output logic      [7:0]  alu_result,
   output logic      [7:0]  nv_rdata
);
   logic [7:0]  regs_r [`REG_COUNT];
   logic [7:0]  regs_nxt [`REG_COUNT];
   logic [7:0]  sram_r [`SRAM_WORDS];
   logic [7:0]  nv_r [`NV_BYTES];
   logic [10:0] pc_r;
   logic [10:0] pc_nxt;
   logic [15:0] ptr1;
   logic [15:0] ptr2;
   logic [15:0] ptr3;
   logic [15:0] ptr_sel_val;
   logic [15:0] ptr_new;
   logic [4:0]  ptr_lo_idx;
   logic        ptr_update;
   logic [15:0] eff_addr;
   logic [3:0]  region;
   logic [7:0]  region_off;
   logic [7:0]  alu_val;
   logic [7:0]  load_val;
   logic        sram_we;
   logic        io_hit;
   logic [10:0] pc_step_target;
   logic [10:0] prog_addr_nxt;
   logic        const_hi_nxt;
   logic [10:0] pc_d_r;
   logic [10:0] prog_addr_r;
   logic        const_hi_r;
   logic [7:0]  const_byte_r;
   logic [15:0] data_addr_r;
   logic [3:0]  data_region_r;
   logic [5:0]  io_port_addr_r;
   logic        io_we_r;
   logic        io_re_r;
   logic [7:0]  io_wdata_r;
   logic [7:0]  read_data_r;
   logic [7:0]  alu_result_r;
   logic [7:0]  nv_rdata_r;

   // Pair index to low register index
   function automatic logic [4:0] pair_lo(input logic [1:0] sel);
      case (sel)
         PTR_FIRST:  pair_lo = `PTR1_LO;
         PTR_SECOND: pair_lo = `PTR2_LO;
         default:    pair_lo = `PTR3_LO;
      endcase
   endfunction : pair_lo

   // Read a pointer pair from the register array
   function automatic logic [15:0] pair_val(input logic [7:0] hi, input logic [7:0] lo);
      pair_val = {hi, lo};
   endfunction : pair_val

   assign ptr1        = pair_val(regs_r[`PTR1_LO + 1], regs_r[`PTR1_LO]);
   assign ptr2        = pair_val(regs_r[`PTR2_LO + 1], regs_r[`PTR2_LO]);
   assign ptr3        = pair_val(regs_r[`PTR3_LO + 1], regs_r[`PTR3_LO]);
   assign ptr_lo_idx  = pair_lo(ptr_sel);
   assign ptr_sel_val = (ptr_sel == PTR_FIRST) ? ptr1 : (ptr_sel == PTR_SECOND) ? ptr2 : ptr3;

   // Effective data address per mode
   always_comb begin
      eff_addr   = 16'h0000;
      ptr_new    = ptr_sel_val;
      ptr_update = 1'b0;
      case (data_mode)
         MODE_IO:       eff_addr = `IO_BASE + {10'h000, io_addr};
         MODE_DIRECT:   eff_addr = second_word;
         MODE_DISP:     eff_addr = ((ptr_sel == PTR_SECOND) ? ptr2 : ptr3) + {10'h000, disp};
         MODE_INDIRECT: eff_addr = ptr_sel_val;
         MODE_PREDEC: begin
            ptr_new    = ptr_sel_val - `PTR_STEP;
            eff_addr   = ptr_new;
            ptr_update = 1'b1;
         end
         MODE_POSTINC: begin
            ptr_new    = ptr_sel_val + `PTR_STEP;
            eff_addr   = ptr_sel_val;
            ptr_update = 1'b1;
         end
         default:       eff_addr = 16'h0000;
      endcase
   end

   data_decoder u_dec (
      .addr   (eff_addr),
      .region (region),
      .offset (region_off)
   );

   always_comb begin
      case (alu_op)
         3'h0:    alu_val = 8'(regs_r[dest_reg] + regs_r[source_operand_reg]);
         3'h1:    alu_val = 8'(regs_r[dest_reg] - regs_r[source_operand_reg]);
         3'h2:    alu_val = regs_r[dest_reg] & regs_r[source_operand_reg];
         3'h3:    alu_val = regs_r[dest_reg] | regs_r[source_operand_reg];
         3'h4:    alu_val = regs_r[dest_reg] ^ regs_r[source_operand_reg];
         3'h5:    alu_val = regs_r[source_operand_reg];
         3'h6:    alu_val = regs_r[dest_reg] & ~regs_r[source_operand_reg];
         default: alu_val = regs_r[dest_reg];
      endcase
   end

   // Data read mux across regions
   always_comb begin
      case (region)
         REGION_REGFILE: load_val = regs_r[region_off[4:0]];
         REGION_IO:      load_val = io_rdata;
         REGION_SRAM:    load_val = sram_r[region_off[6:0]];
         default:        load_val = 8'h00;
      endcase
   end

   assign io_hit  = instr_valid && (data_mode != MODE_NONE) && (data_mode != MODE_REG2)
                    && (data_mode != MODE_CONST) && (region == REGION_IO);
   assign sram_we = instr_valid && data_write && (data_mode != MODE_NONE) && (data_mode != MODE_REG2)
                    && (data_mode != MODE_CONST) && (region == REGION_SRAM);

   // Register file next state
   always_comb begin
      for (int i = 0; i < `REG_COUNT; i++) begin
         regs_nxt[i] = regs_r[i];
      end
      if (instr_valid) begin
         case (data_mode)
            MODE_REG2: regs_nxt[dest_reg] = alu_val;
            MODE_CONST: regs_nxt[dest_reg] = const_byte_r;
            MODE_IO, MODE_DIRECT, MODE_DISP, MODE_INDIRECT, MODE_PREDEC, MODE_POSTINC: begin
               if (!data_write) begin
                  regs_nxt[dest_reg] = load_val;
               end else if (data_write && region == REGION_REGFILE) begin
                  regs_nxt[region_off[4:0]] = regs_r[source_operand_reg];
               end
               if (ptr_update) begin
                  regs_nxt[ptr_lo_idx]      = ptr_new[7:0];
                  regs_nxt[ptr_lo_idx + 1]  = ptr_new[15:8];
               end
            end
            default: regs_nxt[dest_reg] = regs_r[dest_reg];
         endcase
      end
   end

   // Program counter next value
   pc_unit u_pc (
      .pc      (pc_r),
      .pc_mode (pc_mode),
      .rel_k   (rel_k),
      .ptr3    (ptr3),
      .pc_next (pc_step_target)
   );

   assign pc_nxt = instr_valid ? pc_step_target : pc_r;

   // word from upper bits, byte from bit 0
   assign prog_addr_nxt = (instr_valid && data_mode == MODE_CONST) ? ptr3[11:1] : pc_nxt;
   assign const_hi_nxt  = ptr3[0];

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < `REG_COUNT; i++) begin
            regs_r[i] <= `REG_RESET;
         end
         pc_r           <= `PC_RESET;
         pc_d_r         <= `PC_RESET;
         prog_addr_r    <= `PC_RESET;
         const_hi_r     <= 1'b0;
         const_byte_r   <= 8'h00;
         data_addr_r    <= 16'h0000;
         data_region_r  <= REGION_REGFILE;
         io_port_addr_r <= 6'h00;
         io_we_r        <= 1'b0;
         io_re_r        <= 1'b0;
         io_wdata_r     <= 8'h00;
         read_data_r    <= 8'h00;
         alu_result_r   <= 8'h00;
      end else begin
         regs_r         <= regs_nxt;
         pc_r           <= pc_nxt;
         pc_d_r         <= pc_nxt;
         prog_addr_r    <= prog_addr_nxt;
         const_hi_r     <= const_hi_nxt;
         const_byte_r   <= const_hi_r ? prog_word[15:8] : prog_word[7:0];
         data_addr_r    <= eff_addr;
         data_region_r  <= region;
         io_port_addr_r <= region_off[5:0];
         io_we_r        <= io_hit && data_write;
         io_re_r        <= io_hit && !data_write;
         io_wdata_r     <= regs_r[source_operand_reg];
         read_data_r    <= load_val;
         alu_result_r   <= alu_val;
      end
   end

   // SRAM and nonvolatile storage, no reset
   always_ff @(posedge clk) begin
      if (sram_we) begin
         sram_r[region_off[6:0]] <= regs_r[source_operand_reg];
      end
      if (nv_write) begin
         nv_r[nv_addr] <= nv_wdata;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         nv_rdata_r <= 8'h00;
      end else if (nv_read) begin
         nv_rdata_r <= nv_r[nv_addr];
      end
   end

   assign program_counter = pc_d_r;
   assign prog_addr       = prog_addr_r;
   assign const_high_byte = const_hi_r;
   assign const_byte      = const_byte_r;
   assign data_addr       = data_addr_r;
   assign data_region     = data_region_r;
   assign io_port_addr    = io_port_addr_r;
   assign io_we           = io_we_r;
   assign io_re           = io_re_r;
   assign io_wdata        = io_wdata_r;
   assign read_data       = read_data_r;
   assign alu_result      = alu_result_r;
   assign nv_rdata        = nv_rdata_r;
endmodule : address_generation_unit
`default_nettype wire

// ### bench/agu_checker_assertions.sv
// Assertion checker for the address generation unit
`timescale 1ns/10ps
`default_nettype none
module agu_checker
   import agu_pkg::*;
(
   input wire logic        clk,
   input wire logic        rst,
   input wire logic        instr_valid,
   input wire logic [8:0]  data_mode,
   input wire logic        data_write,
   input wire logic [1:0]  ptr_sel,
   input wire logic [5:0]  io_addr,
   input wire logic [15:0] second_word,
   input wire logic [3:0]  pc_mode,
   input wire logic [11:0] rel_k,
   input wire logic        nv_write,
   input wire logic        nv_read,
   input wire logic [7:0]  nv_addr,
   input wire logic [7:0]  nv_wdata,
   input wire logic [10:0] program_counter,
   input wire logic [15:0] data_addr,
   input wire logic [3:0]  data_region,
   input wire logic [5:0]  io_port_addr,
   input wire logic        io_we,
   input wire logic [7:0]  nv_rdata
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   sequence s_op(m);
      instr_valid && data_mode == m;
   endsequence
   sequence s_pair(m);
      s_op(m) ##1 (instr_valid && data_mode == m && $stable(ptr_sel));
   endsequence
   function automatic logic [3:0] region_of(logic [15:0] a);
      return a < 16'h0020 ? REGION_REGFILE : a < 16'h0060 ? REGION_IO : a < 16'h00e0 ? REGION_SRAM : REGION_NONE;
   endfunction : region_of
   chk_io_offset: assert property (s_op(MODE_IO) |=> data_addr == 16'h0020 + 16'($past(io_addr)))
      else $error("io offset wrong");
   chk_io_store: assert property (s_op(MODE_IO) ##0 data_write |=> io_we && io_port_addr == $past(io_addr))
      else $error("io store wrong");
   chk_direct_addr: assert property (s_op(MODE_DIRECT) |=> data_addr == $past(second_word))
      else $error("direct address wrong");
   chk_region_map: assert property (s_op(MODE_DIRECT) |=> data_region == region_of(data_addr))
      else $error("region wrong");
   chk_pc_rel: assert property (instr_valid && pc_mode == PCM_RELATIVE |=>
      program_counter == 11'($past(program_counter) + $past(rel_k) + 12'h001)) else $error("relative pc wrong");
   chk_predec_step: assert property (s_pair(MODE_PREDEC) |=> data_addr == $past(data_addr) - 16'h0001)
      else $error("predecrement wrong");
   chk_postinc_step: assert property (s_pair(MODE_POSTINC) |=> data_addr == $past(data_addr) + 16'h0001)
      else $error("postincrement wrong");
   chk_nv_readback: assert property (nv_write ##1 (nv_read && $stable(nv_addr)) |=> nv_rdata == $past(nv_wdata, 2))
      else $error("nv readback wrong");
endmodule : agu_checker
`default_nettype wire

// ### bench/address_generation_unit_tb_top.sv
// Self-checking testbench for the address generation unit
`timescale 1ns/10ps
`default_nettype none
module address_generation_unit_tb_top
   import agu_pkg::*;
;
   logic        clk = 1'b0, rst = 1'b1, instr_valid = 1'b0, data_write = 1'b0, nv_write = 1'b0, nv_read = 1'b0;
   logic [8:0]  data_mode = MODE_NONE;
   logic [1:0]  ptr_sel = 2'h0;
   logic [4:0]  dest_reg = 5'h00, source_operand_reg = 5'h00;
   logic [5:0]  io_addr = 6'h00, disp = 6'h00, io_port_addr;
   logic [15:0] second_word = 16'h0000, data_addr;
   wire logic [15:0] prog_word;
   logic [2:0]  alu_op = 3'h0;
   logic [3:0]  pc_mode = PCM_NEXT, pcm = PCM_NEXT, data_region, rg;
   logic [11:0] rel_k = 12'h000, kk = 12'h000;
   logic [7:0]  io_rdata = 8'h00, nv_addr = 8'h00, nv_wdata = 8'h00, rf [32] = '{default: 8'h00};
   logic [7:0]  const_byte, read_data, alu_result, nv_rdata, io_wdata;
   logic [7:0]  opa, opb, res;
   logic [10:0] program_counter, prog_addr, pc_e = 11'h000;
   logic        const_high_byte, io_we, io_re;
   logic [15:0] da [7] = '{16'h0000, 16'h001f, 16'h0020, 16'h005f, 16'h0060, 16'h00df, 16'h00e0};
   logic [15:0] xa [6] = '{16'h0100, 16'h00ff, 16'h00fe, 16'h00fe, 16'h00ff, 16'h0100};
   logic [8:0]  xm [6] = '{MODE_INDIRECT, MODE_PREDEC, MODE_PREDEC, MODE_POSTINC, MODE_POSTINC, MODE_INDIRECT};
   logic [7:0]  pv [6] = '{8'h00, 8'h01, 8'h60, 8'h00, 8'h23, 8'h01};
   typedef struct {int due; int k; logic [15:0] v;} note_t;
   note_t q[$];
   int n_fail = 0, checks_done = 0, ncyc = 0, seed = 81853;
   address_generation_unit address_generation_unit_inst (.*);
   // Program memory model
   assign prog_word = {prog_addr[7:0], ~prog_addr[7:0]};
   always #12.5 clk = ~clk;
   function automatic logic [15:0] got(int k);
      case (k)
         0: return data_addr;
         1: return 16'(data_region);
         2: return 16'(io_port_addr);
         3: return 16'(io_we);
         4: return 16'(io_re);
         5: return 16'(io_wdata);
         6: return 16'(read_data);
         7: return 16'(alu_result);
         8: return 16'(nv_rdata);
         9: return 16'(program_counter);
         10: return 16'(prog_addr);
         11: return 16'(const_high_byte);
         default: return 16'(const_byte);
      endcase
   endfunction : got
   task automatic note(int k, logic [15:0] v, int d);
      q.push_back('{ncyc + d, k, v});
   endtask : note
   task automatic cmp_val(logic [15:0] g, logic [15:0] e, int k);
      checks_done++;
      if (g !== e) begin
         n_fail++;
         $display("mismatch at %0t: output %0d got %h expected %h", $time, k, g, e);
      end
   endtask : cmp_val
   // Results compared in order of arrival
   always @(negedge clk) begin
      while (q.size() > 0 && q[0].due <= ncyc) begin
         cmp_val(got(q[0].k), q[0].v, q[0].k);
         q.delete(0);
      end
      ncyc++;
   end
   task automatic op(logic [8:0] m, logic w, logic [1:0] ps, logic [4:0] d, logic [4:0] s, logic [15:0] v);
      @(posedge clk);
      instr_valid <= 1'b1;
      data_mode <= m;
      data_write <= w;
      ptr_sel <= ps;
      dest_reg <= d;
      source_operand_reg <= s;
      second_word <= v;
      io_addr <= v[5:0];
      disp <= v[5:0];
      io_rdata <= v[15:8];
      pc_mode <= pcm;
      rel_k <= kk;
      case (pcm)
         PCM_SKIP2: pc_e = pc_e + 11'h002;
         PCM_INDIRECT: pc_e = {rf[31][2:0], rf[30]};
         PCM_RELATIVE: pc_e = pc_e + kk[10:0] + 11'h001;
         default: pc_e = pc_e + 11'h001;
      endcase
      note(9, 16'(pc_e), 1);
      if (m == MODE_IO && !w) rf[d] = v[15:8];
      pcm = PCM_NEXT;
   endtask : op
   task automatic idle();
      @(posedge clk);
      instr_valid <= 1'b0;
   endtask : idle
   task automatic done(string s);
      $display("test %s done at %0t", s, $time);
   endtask : done
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : end_sim
   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      foreach (pv[i]) begin
         op(MODE_IO, 1'b0, 2'h0, 5'h1a + 5'(i), 5'h00, {pv[i], 8'(i)});
         note(0, 16'h0020 + 16'(i), 1);
         note(1, 16'(REGION_IO), 1);
         note(4, 16'h0001, 1);
         note(6, 16'(pv[i]), 1);
      end
      foreach (xm[i]) begin
         op(xm[i], 1'b1, 2'h0, 5'h00, 5'h00, 16'h0000);
         note(0, xa[i], 1);
      end
      op(MODE_DISP, 1'b1, 2'h1, 5'h00, 5'h00, 16'h003f);
      note(0, 16'h009f, 1);
      op(MODE_DISP, 1'b1, 2'h2, 5'h00, 5'h00, 16'h0005);
      note(0, 16'h0128, 1);
      done("pointers");
      foreach (da[i]) begin
         rg = da[i] < 16'h0020 ? REGION_REGFILE : da[i] < 16'h0060 ? REGION_IO :
              da[i] < 16'h00e0 ? REGION_SRAM : REGION_NONE;
         op(MODE_DIRECT, 1'b1, 2'h0, 5'h00, rg == REGION_REGFILE ? da[i][4:0] : 5'h1c, da[i]);
         note(0, da[i], 1);
         note(1, 16'(rg), 1);
         note(3, 16'(rg == REGION_IO), 1);
      end
      op(MODE_DIRECT, 1'b0, 2'h0, 5'h02, 5'h00, 16'h0060);
      note(6, 16'h0060, 1);
      op(MODE_DIRECT, 1'b0, 2'h0, 5'h03, 5'h00, 16'h00e0);
      note(6, 16'h0000, 1);
      done("direct");
      op(MODE_REG2, 1'b0, 2'h0, 5'h1e, 5'h1c, 16'h0000);
      note(7, 16'h0083, 1);
      op(MODE_REG2, 1'b0, 2'h0, 5'h1e, 5'h1c, 16'h0000);
      note(7, 16'h00e3, 1);
      opa = 8'($random(seed));
      opb = 8'($random(seed));
      op(MODE_IO, 1'b0, 2'h0, 5'h05, 5'h00, {opa, 8'h01});
      op(MODE_IO, 1'b0, 2'h0, 5'h06, 5'h00, {opb, 8'h02});
      for (int j = 0; j < 8; j++) begin
         op(MODE_REG2, 1'b0, 2'h0, 5'h05, 5'h06, 16'h0000);
         alu_op <= 3'(j);
         case (j)
            0: res = opa + opb;
            1: res = opa - opb;
            2: res = opa & opb;
            3: res = opa | opb;
            4: res = opa ^ opb;
            5: res = opb;
            6: res = opa & ~opb;
            default: res = opa;
         endcase
         note(7, 16'(res), 1);
         opa = res;
      end
      rf[30] = 8'he3;
      op(MODE_IO, 1'b1, 2'h0, 5'h00, 5'h1e, 16'h0015);
      note(5, 16'h00e3, 1);
      note(3, 16'h0001, 1);
      note(2, 16'h0015, 1);
      op(MODE_CONST, 1'b0, 2'h2, 5'h04, 5'h00, 16'h0000);
      note(10, 16'h00f1, 1);
      note(11, 16'h0001, 1);
      note(12, 16'h00f1, 2);
      op(MODE_IO, 1'b0, 2'h0, 5'h1e, 5'h00, 16'he200);
      op(MODE_CONST, 1'b0, 2'h2, 5'h04, 5'h00, 16'h0000);
      note(11, 16'h0000, 1);
      note(12, 16'h000e, 2);
      done("alu and constant");
      for (int i = 0; i < 24; i++) begin
         kk = i == 2 ? 12'h800 : i == 3 ? 12'h7ff : 12'($random(seed));
         pcm = i == 0 ? PCM_INDIRECT : i == 1 ? PCM_SKIP2 : PCM_RELATIVE;
         op(MODE_NONE, 1'b0, 2'h0, 5'h00, 5'h00, 16'($random(seed)));
      end
      idle();
      done("program counter");
      repeat (4) begin
         @(posedge clk);
         nv_write <= 1'b1;
         nv_addr <= 8'($random(seed));
         nv_wdata <= 8'($random(seed));
         @(posedge clk);
         nv_write <= 1'b0;
         nv_read <= 1'b1;
         note(8, 16'(nv_wdata), 1);
         @(posedge clk);
         nv_read <= 1'b0;
      end
      repeat (3) @(posedge clk);
      done("nonvolatile");
      end_sim();
   end
   // Watchdog
   initial begin
      repeat (2000) @(posedge clk);
      n_fail++;
      end_sim();
   end
endmodule : address_generation_unit_tb_top
bind address_generation_unit agu_checker agu_checker_inst (.*);
`default_nettype wire
